// ---- src/pcspc_top.sv ----
// Purpose: Pixel and sound clock selection with PLL phase comparator, AXI4-Lite registers
// Assumes: All clock inputs are synchronous levels sampled on aclk
// Notes: Derived clocks leave as one-cycle enables; pump pin is two signals
//
// What this block does
// - Pixel clock source chosen by video control bits 1:0.
// - Selected pixel clock divided by 1 to 8 from control bits 4:2.
// - Sound runs from 32 MHz reference or sound clock input, halved.
// - High-frequency input serves only the fastest pixel rates above VCO range.
// - Two pre-loadable down counters, on reference and VCO, moduli from synth register.
// - Modulus fields hold modulus minus one; counters honour that.
// - Locked loop settles VCO at reference times v over r.
// - Pump output is high impedance unless a correction is needed.
// - Pump driven high to speed VCO up, low to slow it.
// - VCO feedback input is the pixel clock in PLL use.
// - Synth bit 6 forces pump driven high unless bit 14 is also set.
// - Synth bit 7 clears reference counter; bit 14 forces pump driven low.
// - Synth bit 15 clears VCO counter.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pcspc_top
  import pcspc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock source inputs
  input wire logic high_freq_clock_in,
  input wire logic vco_feedback_clock_in,
  input wire logic internal_ref_clock_32,
  input wire logic sound_clock_in,
  // Derived enables
  output logic pixel_clock_en,
  output logic sound_clock_en,
  // VCO bias and pump pin
  output logic vco_feedback_inverted_out,
  output logic phase_pump_out,
  output logic phase_pump_oe
);

  typedef struct packed {
    pcspc_ctrl_type ctrl;
    pcspc_synth_type synth;
    logic [3:0] edge_prev;
    pcspc_pd_type pd;
    logic pump_oe;
    logic pump_val;
    logic vco_inv;
    logic snd_div;
    logic snd_en;
    logic aw_pend;
    logic [7:0] aw_addr;
    logic w_pend;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pcspc_top_type;

  pcspc_top_type s_r;
  pcspc_top_type s_nxt;

  logic [3:0] edge_in;
  logic [3:0] edge_rise;
  logic pix_tick;
  logic snd_tick;
  logic [1:0] cnt_tick;
  logic [1:0] cnt_clear;
  logic [MOD_W-1:0] cnt_mod [2];
  logic [1:0] cnt_term;
  logic [MOD_W-1:0] cnt_val [2];
  logic r_term;
  logic v_term;

  // Word-aligned register decode shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    logic [1:0] sel;
    sel = 2'h3;
    if (addr == OFS_VIDEO_CTRL)
    begin
      sel = 2'h0;
    end
    else if (addr == OFS_SYNTH)
    begin
      sel = 2'h1;
    end
    else if (addr == OFS_STATUS)
    begin
      sel = 2'h2;
    end
    return sel;
  endfunction : reg_sel

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Inputs are synchronous, so a single previous-value flop finds edges
  assign edge_in[EDGE_HF] = high_freq_clock_in;
  assign edge_in[EDGE_VCO] = vco_feedback_clock_in;
  assign edge_in[EDGE_REF] = internal_ref_clock_32;
  assign edge_in[EDGE_SND] = sound_clock_in;
  assign edge_rise = edge_in & ~s_r.edge_prev;

  // Pixel source; high-frequency input is for rates past the VCO limit
  always_comb
  begin
    unique case (s_r.ctrl.pix_src)
      SRC_HIGH_FREQ: pix_tick = edge_rise[EDGE_HF];
      SRC_VCO: pix_tick = edge_rise[EDGE_VCO];
      default: pix_tick = edge_rise[EDGE_REF];
    endcase
  end

  pcspc_prescaler pcspc_prescaler_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(pix_tick),
    .ratio_m1(s_r.ctrl.prescale_m1),
    .pulse(pixel_clock_en)
  );

  assign snd_tick = s_r.ctrl.sound_ext ? edge_rise[EDGE_SND] : edge_rise[EDGE_REF];

  // Counter 0 on reference, counter 1 on VCO feedback
  assign cnt_tick = {edge_rise[EDGE_VCO], edge_rise[EDGE_REF]};
  assign cnt_clear = {s_r.synth.clr_v, s_r.synth.clr_r};
  assign cnt_mod[0] = s_r.synth.r_m1;
  assign cnt_mod[1] = s_r.synth.v_m1;

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_cnt
      pcspc_down_counter pcspc_down_counter_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(cnt_tick[g]),
        .clear(cnt_clear[g]),
        .modulus_m1(cnt_mod[g]),
        .terminal(cnt_term[g]),
        .count(cnt_val[g])
      );
    end
  endgenerate

  assign r_term = cnt_term[0];
  assign v_term = cnt_term[1];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.edge_prev = edge_in;
    s_nxt.vco_inv = ~vco_feedback_clock_in;

    // Sound divide-by-two
    s_nxt.snd_en = 1'b0;
    if (snd_tick)
    begin
      s_nxt.snd_div = ~s_r.snd_div;
      s_nxt.snd_en = s_r.snd_div;
    end

    // Phase detector: the side whose terminal event comes first leads.
    // Tracking terminal events keeps the loop at F_ref * v / r.
    unique case (s_r.pd)
      PD_IDLE:
      begin
        if (r_term && !v_term)
        begin
          s_nxt.pd = PD_UP;
        end
        else if (v_term && !r_term)
        begin
          s_nxt.pd = PD_DOWN;
        end
      end
      PD_UP:
      begin
        if (v_term && !r_term)
        begin
          s_nxt.pd = PD_IDLE;
        end
      end
      PD_DOWN:
      begin
        if (r_term && !v_term)
        begin
          s_nxt.pd = PD_IDLE;
        end
      end
      default: s_nxt.pd = PD_IDLE;
    endcase

    // Forced low wins so the recovery setting can never race the VCO upward
    if (s_r.synth.force_low)
    begin
      s_nxt.pump_oe = 1'b1;
      s_nxt.pump_val = 1'b0;
    end
    else if (s_r.synth.force_high)
    begin
      s_nxt.pump_oe = 1'b1;
      s_nxt.pump_val = 1'b1;
    end
    else
    begin
      s_nxt.pump_oe = (s_nxt.pd != PD_IDLE);
      s_nxt.pump_val = (s_nxt.pd == PD_UP);
    end

    // Responses retire first; the channel takes a new request the cycle after the handshake
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end

    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_pend = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_pend = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end

    // Write commits one cycle after both halves are held
    if (s_r.aw_pend && s_r.w_pend && !s_r.bvalid)
    begin
      s_nxt.aw_pend = 1'b0;
      s_nxt.w_pend = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (reg_sel(s_r.aw_addr))
        2'h0:
        begin
          s_nxt.ctrl = pcspc_ctrl_type'(CTRL_W'(merge_bytes(32'(s_r.ctrl), s_r.w_data,
                                                            s_r.w_strb)));
        end
        2'h1:
        begin
          s_nxt.synth = pcspc_synth_type'(SYNTH_W'(merge_bytes(32'(s_r.synth), s_r.w_data,
                                                               s_r.w_strb)));
        end
        2'h2:
        begin
          // Status is read-only; writes are accepted and dropped
        end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end

    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = '0;
      unique case (reg_sel(s_axi_araddr))
        2'h0: s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
        2'h1: s_nxt.rdata[SYNTH_W-1:0] = s_r.synth;
        2'h2:
        begin
          s_nxt.rdata[STAT_PUMP_OE_BIT] = s_r.pump_oe;
          s_nxt.rdata[STAT_PUMP_VAL_BIT] = s_r.pump_val;
          s_nxt.rdata[STAT_RCNT_LSB +: MOD_W] = cnt_val[0];
          s_nxt.rdata[STAT_VCNT_LSB +: MOD_W] = cnt_val[1];
        end
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
  end

  assign s_axi_awready = !s_r.aw_pend && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_pend && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  assign sound_clock_en = s_r.snd_en;
  assign vco_feedback_inverted_out = s_r.vco_inv;
  assign phase_pump_oe = s_r.pump_oe;
  assign phase_pump_out = s_r.pump_val;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      s_r.synth <= SYNTH_RESET;
      s_r.pd <= PD_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : pcspc_top
`default_nettype wire

// ---- src/pcspc_pkg.sv ----
// Purpose: Shared constants and types for the pixel clock selector and phase comparator
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: Register fields are packed so that a cast of the low bits gives the struct
package pcspc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // Register byte offsets
  localparam logic [7:0] OFS_VIDEO_CTRL = 8'h00;
  localparam logic [7:0] OFS_SYNTH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Field layout
  localparam int unsigned CTRL_W = 6;
  localparam int unsigned SYNTH_W = 16;
  localparam int unsigned MOD_W = 6;
  localparam int unsigned PRE_W = 3;
  localparam int unsigned STAT_PUMP_OE_BIT = 0;
  localparam int unsigned STAT_PUMP_VAL_BIT = 1;
  localparam int unsigned STAT_RCNT_LSB = 8;
  localparam int unsigned STAT_VCNT_LSB = 16;

  // Pixel clock source codes
  localparam logic [1:0] SRC_HIGH_FREQ = 2'h0;
  localparam logic [1:0] SRC_VCO = 2'h1;
  localparam logic [1:0] SRC_REF = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic sound_ext;
    logic [PRE_W-1:0] prescale_m1;
    logic [1:0] pix_src;
  } pcspc_ctrl_type;

  typedef struct packed {
    logic clr_v;
    logic force_low;
    logic [MOD_W-1:0] v_m1;
    logic clr_r;
    logic force_high;
    logic [MOD_W-1:0] r_m1;
  } pcspc_synth_type;

  localparam pcspc_ctrl_type CTRL_RESET = '0;
  localparam pcspc_synth_type SYNTH_RESET = '0;

  typedef enum logic [1:0] {
    PD_IDLE,
    PD_UP,
    PD_DOWN
  } pcspc_pd_type;

  // Edge detector slots
  localparam int unsigned EDGE_HF = 0;
  localparam int unsigned EDGE_VCO = 1;
  localparam int unsigned EDGE_REF = 2;
  localparam int unsigned EDGE_SND = 3;

endpackage : pcspc_pkg

// ---- src/pcspc_down_counter.sv ----
// Purpose: Pre-loadable down counter of the phase comparator
// Assumes: tick is a one-cycle pulse per edge of the counted clock
// Notes: Period is modulus_m1 + 1 ticks; terminal is combinational
`timescale 1ns/1ns
`default_nettype none
module pcspc_down_counter
  import pcspc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic clear,
  input wire logic [MOD_W-1:0] modulus_m1,
  // Result
  output logic terminal,
  output logic [MOD_W-1:0] count
);

  typedef struct packed {
    logic [MOD_W-1:0] cnt;
  } pcspc_cnt_type;

  pcspc_cnt_type s_r;
  pcspc_cnt_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (clear)
    begin
      s_nxt.cnt = '0;
    end
    else if (tick)
    begin
      // Reload on zero so the field holds modulus minus one
      if (s_r.cnt == '0)
      begin
        s_nxt.cnt = modulus_m1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  assign terminal = tick && !clear && (s_r.cnt == '0);
  assign count = s_r.cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : pcspc_down_counter
`default_nettype wire

// ---- src/pcspc_prescaler.sv ----
// Purpose: Divide-by-1-to-8 pre-scaler for the selected pixel clock
// Assumes: tick is a one-cycle pulse per edge of the selected source
// Notes: Ratio change takes effect at the next wrap or immediately if below count
`timescale 1ns/1ns
`default_nettype none
module pcspc_prescaler
  import pcspc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic [PRE_W-1:0] ratio_m1,
  // Divided enable
  output logic pulse
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
    logic pulse;
  } pcspc_pre_type;

  pcspc_pre_type s_r;
  pcspc_pre_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    if (tick)
    begin
      if (s_r.cnt >= ratio_m1)
      begin
        s_nxt.cnt = '0;
        s_nxt.pulse = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  assign pulse = s_r.pulse;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : pcspc_prescaler
`default_nettype wire

// ---- verification/pcspc_properties.sv ----
// Purpose: Port-level checks of bus timing, pump forcing and enables
// Assumes: Full-word writes; the synth shadow ignores wstrb
// Notes: Shadow updates one edge after bvalid rises, as the pump does
`timescale 1ns/1ns
`default_nettype none
module pcspc_properties
  import pcspc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Enables and pump
  input wire logic pixel_clock_en,
  input wire logic sound_clock_en,
  input wire logic phase_pump_out,
  input wire logic phase_pump_oe,
  // Oscillator bias
  input wire logic vco_feedback_clock_in,
  input wire logic vco_feedback_inverted_out
);
  logic [7:0] aw_r;
  logic [15:0] wd_r;
  logic [15:0] sh_r;
  logic bv_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_r <= '0;
      wd_r <= '0;
      sh_r <= '0;
      bv_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wd_r <= s_axi_wdata[15:0];
      if (s_axi_bvalid && !bv_r && aw_r == OFS_SYNTH)
        sh_r <= wd_r;
      bv_r <= s_axi_bvalid;
    end
  end

  a_force_low: assert property (sh_r[14] |-> phase_pump_oe && !phase_pump_out)
    else $error("pump not forced low");
  a_force_high: assert property (sh_r[6] && !sh_r[14] |-> phase_pump_oe && phase_pump_out)
    else $error("pump not forced high");
  a_sound_gap: assert property (sound_clock_en |=> !sound_clock_en [*3])
    else $error("sound enable not halved");
  // A source switch at a write commit may put two ticks back to back
  a_pixel_gap: assert property (pixel_clock_en && !s_axi_bvalid |=> !pixel_clock_en)
    else $error("pixel enable too dense");
  // First edge after reset still holds the cleared bias flop
  a_bias_invert: assert property ($past(aresetn)
    |-> vco_feedback_inverted_out == !$past(vco_feedback_clock_in))
    else $error("bias output not inverted");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h02
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  c_forced_low: cover property (sh_r[14] && phase_pump_oe);
  c_pump_up: cover property (phase_pump_oe && phase_pump_out && !sh_r[6]);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : pcspc_properties
`default_nettype wire

// ---- verification/pcspc_vco_model.sv ----
// Purpose: Behavioural loop filter and VCO behind the pump pin
// Assumes: Half period in aclk cycles, held between 2 and 12
// Notes: Freeze fixes the rate so divide checks stay exact
`timescale 1ns/1ns
`default_nettype none
module pcspc_vco_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pump pin and control
  input wire logic pump,
  input wire logic pump_oe,
  input wire logic freeze,
  // Oscillator
  output logic vco,
  output int hp
);
  int ph;
  int acc;
  int thr;

  // Proportional nudge keeps the loop from ringing
  always_comb thr = hp + ((pump_oe && !freeze) ? (pump ? -1 : 1) : 0);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hp <= 6;
      ph <= 0;
      acc <= 0;
      vco <= 1'b0;
    end
    else
    begin
      if (ph + 1 >= thr)
      begin
        ph <= 0;
        vco <= ~vco;
      end
      else
        ph <= ph + 1;
      // Released pin: filter holds its charge
      if (pump_oe && !freeze)
        acc <= acc + (pump ? -1 : 1);
      if (acc > 15)
      begin
        acc <= 0;
        hp <= (hp < 12) ? hp + 1 : hp;
      end
      if (acc < -15)
      begin
        acc <= 0;
        hp <= (hp > 2) ? hp - 1 : hp;
      end
    end
  end
endmodule : pcspc_vco_model
`default_nettype wire

// ---- verification/test_pixel_clock_select_phase_comparator.sv ----
// Purpose: Self-checking bench for pixel clock select and phase comparator
// Assumes: Bench-made source clocks are slow levels sampled on aclk
// Notes: Lock is judged with one step of slack on the model's rate
`timescale 1ns/1ns
`default_nettype none
module test_pixel_clock_select_phase_comparator
  import pcspc_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, freeze = 1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic high_freq_clock_in = 0, internal_ref_clock_32 = 0, sound_clock_in = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic vco_feedback_clock_in, vco_feedback_inverted_out, phase_pump_out, phase_pump_oe;
  logic pixel_clock_en, sound_clock_en;
  logic [5:0] tb[3] = '{6'h3B, 6'h1F, 6'h1E};
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int hp, g, v, r, n_fail = 0, checked = 0, cyc = 0;
  bit up, dn, z;

  pcspc_top pcspc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_freq_clock_in, .vco_feedback_clock_in,
    .internal_ref_clock_32, .sound_clock_in, .pixel_clock_en, .sound_clock_en,
    .vco_feedback_inverted_out, .phase_pump_out, .phase_pump_oe);
  pcspc_vco_model pcspc_vco_model_inst (.aclk, .aresetn, .pump(phase_pump_out),
    .pump_oe(phase_pump_oe), .freeze, .vco(vco_feedback_clock_in), .hp);

  initial
  begin
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  // Edges every 2, 4 and 6 cycles tell the sources apart
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    high_freq_clock_in <= ~high_freq_clock_in;
    internal_ref_clock_32 <= cyc[1];
    sound_clock_in <= (cyc % 6) < 3;
  end

  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      cmp({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    up <= up | (phase_pump_oe === 1'b1 && phase_pump_out === 1'b1);
    dn <= dn | (phase_pump_oe === 1'b1 && phase_pump_out === 1'b0);
    z <= z | (phase_pump_oe === 1'b0);
  end

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] e);
    bit ta = 0;
    bit tw = 0;
    @(posedge aclk);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (!ta && s_axi_awready)
      begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready)
      begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Skips two pulses so a ratio change has settled
  task automatic gap(input bit s, output int n);
    n = 0;
    repeat (2) do @(posedge aclk); while (!(s ? sound_clock_en : pixel_clock_en));
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!(s ? sound_clock_en : pixel_clock_en));
  endtask : gap

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    g = $urandom(47);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_VIDEO_CTRL, '0);
    rd(OFS_SYNTH, '0);
    rd(8'h0C, {RESP_SLVERR, 32'h0});
    wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
    d = $urandom;
    wr(OFS_VIDEO_CTRL, d, RESP_OKAY);
    rd(OFS_VIDEO_CTRL, {RESP_OKAY, 26'h0, d[5:0]});
    $display("register test done");
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 8; k++)
      begin
        wr(OFS_VIDEO_CTRL, {27'h0, k[2:0], s[1:0]}, RESP_OKAY);
        gap(0, g);
        cmp(34'(g), 34'((k + 1) * (s == 0 ? 2 : (s == 1 ? 2 * hp : 4))));
      end
    for (int e = 0; e < 2; e++)
    begin
      wr(OFS_VIDEO_CTRL, {26'h0, e[0], 5'h0}, RESP_OKAY);
      gap(1, g);
      cmp(34'(g), 34'(e ? 12 : 8));
    end
    $display("clock select test done");
    v = $urandom % 63;
    r = v + 1 + $urandom % (63 - v);
    foreach (tb[i])
    begin
      wr(OFS_SYNTH, {16'h0, tb[i][3:2], v[5:0], tb[i][1:0], r[5:0]}, RESP_OKAY);
      rd(OFS_STATUS, {RESP_OKAY, 30'h0, tb[i][5:4]});
    end
    wr(OFS_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFS_STATUS, {RESP_OKAY, 32'h1});
    cmp({32'h0, phase_pump_oe, phase_pump_out}, 34'h2);
    $display("pump force test done");
    freeze <= 1'b0;
    repeat (600) @(posedge aclk);
    wr(OFS_SYNTH, {16'h0, 2'b11, 6'd1, 2'b10, 6'd3}, RESP_OKAY);
    wr(OFS_SYNTH, {16'h0, 2'b00, 6'd1, 2'b00, 6'd3}, RESP_OKAY);
    // Cleared off the edge so the monitor cannot write back old flags
    @(negedge aclk);
    up = 0;
    dn = 0;
    z = 0;
    repeat (6000) @(posedge aclk);
    cmp(34'(hp >= 3 && hp <= 5), 34'h1);
    cmp({31'h0, up, dn, z}, 34'h7);
    wr(OFS_SYNTH, {16'h0, 8'h01, 8'h05}, RESP_OKAY);
    repeat (6000) @(posedge aclk);
    cmp(34'(hp >= 5 && hp <= 7), 34'h1);
    $display("loop lock test done");
    end_of_test();
  end
endmodule : test_pixel_clock_select_phase_comparator

bind pcspc_top pcspc_properties pcspc_properties_inst (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .pixel_clock_en, .sound_clock_en, .phase_pump_out, .phase_pump_oe, .vco_feedback_clock_in,
  .vco_feedback_inverted_out);
`default_nettype wire
